/* design/ssm_defs.vh */
// Constants for the serial interface master configuration block
// What this block does
// - Lane format field picks one lane full duplex, two or four lanes half duplex.
// - Wide frame size n gives n+1 serial clocks per data frame.
// - Control frame size n gives n+1 serial clocks per control frame.
// - Direction 0 sends and receives together; 1 and 2 only for multi-lane formats.
// - Direction 3 sends the control frame first, then starts receiving.
// - Bit 24 lets the target select line toggle between frames.
// - Bit 11 loops the transmit shifter back into the receive shifter.
// - Sixteen-bit frame count for receive-only and memory read, resets to zero.
// - Select bit 0 low keeps the target deselected, high selects it.
// - Serial clock comes from the bus clock via a sixteen-bit divisor.
// - Eight-bit transmit threshold compared with fill level gives transmit-empty condition.
// - Eight-bit receive threshold compared with receive level gives receive-full condition.
// - Transmit fill count is readable, three bits, resets to zero.
// - Every control or status register is reached in one bus access.
`ifndef SSM_DEFS_VH
`define SSM_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SSM_OFF_CTRL0 8'h00
`define SSM_OFF_CTRL1 8'h04
`define SSM_OFF_ENABLE 8'h08
`define SSM_OFF_WIRE3 8'h0C
`define SSM_OFF_SELECT 8'h10
`define SSM_OFF_DIVIDER 8'h14
`define SSM_OFF_TXTHR 8'h18
`define SSM_OFF_RXTHR 8'h1C
`define SSM_OFF_TXFILL 8'h20
`define SSM_OFF_RXFILL 8'h24
`define SSM_OFF_STATUS 8'h28
`define SSM_OFF_DATA_LO 8'h60
`define SSM_OFF_DATA_HI 8'hEC

// ----------------------------------------------------------------------
// Field positions and write masks
// ----------------------------------------------------------------------
`define SSM_C0_MASK 32'h017FFFFF
`define SSM_C0_TOGGLE 24
`define SSM_C0_LANES 22:21
`define SSM_C0_WIDE 20:16
`define SSM_C0_CTLSZ 15:12
`define SSM_C0_LOOP 11
`define SSM_C0_DIR 9:8
`define SSM_C0_POL 7
`define SSM_C0_PHA 6
`define SSM_LANES_1 2'h0
`define SSM_LANES_2 2'h1
`define SSM_LANES_4 2'h2
`define SSM_DIR_TXRX 2'h0
`define SSM_DIR_TX 2'h1
`define SSM_DIR_RX 2'h2
`define SSM_DIR_MEMRD 2'h3

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define SSM_RST_WORD 32'h00000000
`define SSM_RST_HALF 16'h0000
`define SSM_RST_BYTE 8'h00
`define SSM_FIFO_DEPTH 4
`define SSM_WORD_BITS 32

`endif

/* design/ssm_master.v */
// Serial master register set, transmit FIFO and frame shifter
`timescale 1ns/1ps
`include "ssm_defs.vh"

// ----------------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides
// ----------------------------------------------------------------------
module ssm_fifo #(
  parameter W = 32,
  parameter D = 4,
  parameter AW = 2
) (
  input wire clock,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  output wire [AW:0] count
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // Full and empty come straight from the occupancy count
  assign in_ready = (count_reg != D[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_reg];
  assign count = count_reg;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage is left without reset; only pointers and count need a defined value
  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointer and count update
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push & ~pop) count_reg <= count_reg + 1'b1;
      else if (pop & ~push) count_reg <= count_reg - 1'b1;
    end
  end
endmodule // ssm_fifo

// ----------------------------------------------------------------------
// Top: bus slave, configuration registers, serial engine
// ----------------------------------------------------------------------
module ssm_master (
  input wire clock,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg sclk,
  output reg cs_n,
  output reg [3:0] sd_out,
  output reg [3:0] sd_oe,
  input wire [3:0] sd_in,
  output reg tx_thresh_hit,
  output reg rx_thresh_hit
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_GAP = 3'b100;

  reg [31:0] ctrl0_reg;
  reg [15:0] frame_count_reg;
  reg enable_reg;
  reg [2:0] wire3_reg;
  reg select_reg;
  reg [15:0] divisor_reg;
  reg [7:0] tx_thr_reg;
  reg [7:0] rx_thr_reg;
  reg [31:0] rx_word_reg;
  reg rx_valid_reg;
  reg [3:0] in_meta_reg;
  reg [3:0] in_sync_reg;
  reg [2:0] state_reg;
  reg [15:0] div_cnt_reg;
  reg half_reg;
  reg first_reg;
  reg ctrl_phase_reg;
  reg rx_phase_reg;
  reg gap_rx_reg;
  reg [5:0] clk_left_reg;
  reg [15:0] rx_left_reg;
  reg [31:0] tx_sh_reg;
  reg [31:0] rx_sh_reg;
  reg [31:0] rd_mux;
  reg rd_bad;
  reg [2:0] lanes;
  reg [3:0] out_bits;
  reg [3:0] in_bits;
  reg [31:0] rx_next;
  reg [5:0] dclocks;
  reg [5:0] cclocks;
  reg [7:0] nbits_d;
  reg [7:0] nbits_c;
  reg [31:0] tx_load_d;
  reg [31:0] tx_load_c;
  wire [2:0] fill;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [31:0] fifo_word;
  wire acc;
  wire is_data;
  wire wr_fire;
  wire data_push;
  wire [1:0] dir;
  wire mem_rd;
  wire [15:0] half_div;
  wire tick;
  wire frame_end;
  wire next_rx;
  wire next_tx;
  wire capture;
  wire st_start;
  wire gap_tx;
  wire pop;

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  assign is_data = (paddr >= `SSM_OFF_DATA_LO) && (paddr <= `SSM_OFF_DATA_HI);
  assign acc = psel & penable & pready;
  assign wr_fire = acc & pwrite & ~pslverr;
  assign data_push = wr_fire & is_data;

  // Read mux; misaligned or unmapped offsets answer with an error
  always @* begin
    rd_mux = `SSM_RST_WORD;
    rd_bad = 1'b0;
    case (paddr)
      `SSM_OFF_CTRL0: rd_mux = ctrl0_reg;
      `SSM_OFF_CTRL1: rd_mux = {16'h0000, frame_count_reg};
      `SSM_OFF_ENABLE: rd_mux = {31'h00000000, enable_reg};
      `SSM_OFF_WIRE3: rd_mux = {29'h00000000, wire3_reg};
      `SSM_OFF_SELECT: rd_mux = {31'h00000000, select_reg};
      `SSM_OFF_DIVIDER: rd_mux = {16'h0000, divisor_reg};
      `SSM_OFF_TXTHR: rd_mux = {24'h000000, tx_thr_reg};
      `SSM_OFF_RXTHR: rd_mux = {24'h000000, rx_thr_reg};
      `SSM_OFF_TXFILL: rd_mux = {29'h00000000, fill};
      `SSM_OFF_RXFILL: rd_mux = {31'h00000000, rx_valid_reg};
      `SSM_OFF_STATUS: rd_mux = {28'h0000000, rx_valid_reg, ~fifo_out_valid,
                                 fifo_in_ready, ~state_reg[0]};
      default: begin
        if (is_data && paddr[1:0] == 2'h0) rd_mux = rx_word_reg;
        else rd_bad = 1'b1;
      end
    endcase
  end

  // Answer one cycle after setup; a full FIFO holds the data write off
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `SSM_RST_WORD;
    end else begin
      pready <= psel & ~(penable & pready) &
                ~(pwrite & is_data & ~rd_bad & ~fifo_in_ready);
      pslverr <= psel & ~(penable & pready) & rd_bad;
      if (psel & ~(penable & pready)) prdata <= pwrite ? `SSM_RST_WORD : rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl0_reg <= `SSM_RST_WORD;
      frame_count_reg <= `SSM_RST_HALF;
      enable_reg <= 1'b0;
      wire3_reg <= 3'h0;
      select_reg <= 1'b0;
      divisor_reg <= `SSM_RST_HALF;
      tx_thr_reg <= `SSM_RST_BYTE;
      rx_thr_reg <= `SSM_RST_BYTE;
    end else if (wr_fire) begin
      case (paddr)
        `SSM_OFF_CTRL0: ctrl0_reg <= pwdata & `SSM_C0_MASK;
        `SSM_OFF_CTRL1: frame_count_reg <= pwdata[15:0];
        `SSM_OFF_ENABLE: enable_reg <= pwdata[0];
        `SSM_OFF_WIRE3: wire3_reg <= pwdata[2:0];
        `SSM_OFF_SELECT: select_reg <= pwdata[0];
        `SSM_OFF_DIVIDER: divisor_reg <= pwdata[15:0];
        `SSM_OFF_TXTHR: tx_thr_reg <= pwdata[7:0];
        `SSM_OFF_RXTHR: rx_thr_reg <= pwdata[7:0];
        default: ctrl0_reg <= ctrl0_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Transmit FIFO in the data path
  // ----------------------------------------------------------------------
  ssm_fifo #(.W(`SSM_WORD_BITS), .D(`SSM_FIFO_DEPTH), .AW(2)) u_txq (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(data_push),
    .in_ready(fifo_in_ready),
    .in_data(pwdata),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_word),
    .count(fill)
  );

  // ----------------------------------------------------------------------
  // Lane mapping and frame lengths
  // ----------------------------------------------------------------------
  assign dir = ctrl0_reg[`SSM_C0_DIR];
  assign mem_rd = (dir == `SSM_DIR_RX) | (dir == `SSM_DIR_MEMRD);
  assign capture = rx_phase_reg | (dir == `SSM_DIR_TXRX);

  // Left-justify frames so the top bits leave first on every lane width
  always @* begin
    lanes = 3'd1;
    out_bits = {3'b000, tx_sh_reg[31]};
    in_bits = ctrl0_reg[`SSM_C0_LOOP] ? {3'b000, tx_sh_reg[31]} : {3'b000, in_sync_reg[1]};
    rx_next = {rx_sh_reg[30:0], in_bits[0]};
    if (ctrl0_reg[`SSM_C0_LANES] == `SSM_LANES_2) begin
      lanes = 3'd2;
      out_bits = {2'b00, tx_sh_reg[31:30]};
      in_bits = ctrl0_reg[`SSM_C0_LOOP] ? out_bits : {2'b00, in_sync_reg[1:0]};
      rx_next = {rx_sh_reg[29:0], in_bits[1:0]};
    end else if (ctrl0_reg[`SSM_C0_LANES] == `SSM_LANES_4) begin
      lanes = 3'd4;
      out_bits = tx_sh_reg[31:28];
      in_bits = ctrl0_reg[`SSM_C0_LOOP] ? out_bits : in_sync_reg;
      rx_next = {rx_sh_reg[27:0], in_bits};
    end
    dclocks = {1'b0, ctrl0_reg[`SSM_C0_WIDE]} + 6'd1;
    cclocks = {2'b00, ctrl0_reg[`SSM_C0_CTLSZ]} + 6'd1;
    nbits_d = {2'b00, dclocks} * {5'b00000, lanes};
    nbits_c = {2'b00, cclocks} * {5'b00000, lanes};
    tx_load_d = (nbits_d >= 8'd32) ? fifo_word : (fifo_word << (8'd32 - nbits_d));
    tx_load_c = (nbits_c >= 8'd32) ? fifo_word : (fifo_word << (8'd32 - nbits_c));
  end

  // ----------------------------------------------------------------------
  // Serial clock divider; zero divisor keeps the clock still
  // ----------------------------------------------------------------------
  assign half_div = (divisor_reg[15:1] == 15'h0000) ? 16'h0001 : {1'b0, divisor_reg[15:1]};
  assign tick = ~state_reg[0] & (divisor_reg != `SSM_RST_HALF) &
                (div_cnt_reg == half_div - 16'h0001);
  assign frame_end = state_reg[1] & tick & half_reg & (clk_left_reg == 6'd0);
  assign next_rx = mem_rd & (ctrl_phase_reg | (rx_phase_reg & rx_left_reg != `SSM_RST_HALF));
  assign next_tx = ~mem_rd & fifo_out_valid;
  assign st_start = state_reg[0] & enable_reg & fifo_out_valid;
  assign gap_tx = state_reg[2] & tick & ~gap_rx_reg & fifo_out_valid;
  assign pop = st_start | gap_tx |
               (frame_end & next_tx & ~ctrl0_reg[`SSM_C0_TOGGLE]);

  // ----------------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      div_cnt_reg <= `SSM_RST_HALF;
      half_reg <= 1'b0;
      first_reg <= 1'b0;
      ctrl_phase_reg <= 1'b0;
      rx_phase_reg <= 1'b0;
      gap_rx_reg <= 1'b0;
      clk_left_reg <= 6'd0;
      rx_left_reg <= `SSM_RST_HALF;
      tx_sh_reg <= `SSM_RST_WORD;
      rx_sh_reg <= `SSM_RST_WORD;
      rx_word_reg <= `SSM_RST_WORD;
      rx_valid_reg <= 1'b0;
    end else begin
      div_cnt_reg <= (tick | state_reg[0]) ? `SSM_RST_HALF : div_cnt_reg + 16'h0001;
      // Set wins over the read that drains the received word
      if (acc & ~pwrite & is_data & ~pslverr) rx_valid_reg <= 1'b0;
      if (frame_end & capture) begin
        rx_word_reg <= ctrl0_reg[`SSM_C0_PHA] ? rx_next : rx_sh_reg;
        rx_valid_reg <= 1'b1;
      end
      if (!enable_reg) begin
        state_reg <= ST_IDLE;
        half_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (st_start) begin
              state_reg <= ST_SHIFT;
              first_reg <= 1'b1;
              rx_sh_reg <= `SSM_RST_WORD;
              half_reg <= 1'b0;
              rx_left_reg <= frame_count_reg;
              ctrl_phase_reg <= (dir == `SSM_DIR_MEMRD);
              rx_phase_reg <= (dir == `SSM_DIR_RX);
              tx_sh_reg <= (dir == `SSM_DIR_MEMRD) ? tx_load_c :
                           (dir == `SSM_DIR_RX) ? `SSM_RST_WORD : tx_load_d;
              clk_left_reg <= ((dir == `SSM_DIR_MEMRD) ? cclocks : dclocks) - 6'd1;
            end
          end
          ST_SHIFT: begin
            if (tick & ~half_reg) begin
              // Leading edge
              half_reg <= 1'b1;
              first_reg <= 1'b0;
              if (!ctrl0_reg[`SSM_C0_PHA]) rx_sh_reg <= rx_next;
              else if (!first_reg) tx_sh_reg <= tx_sh_reg << lanes;
            end else if (tick) begin
              // Trailing edge
              half_reg <= 1'b0;
              if (!ctrl0_reg[`SSM_C0_PHA]) tx_sh_reg <= tx_sh_reg << lanes;
              else rx_sh_reg <= rx_next;
              clk_left_reg <= clk_left_reg - 6'd1;
              if (clk_left_reg == 6'd0) begin
                first_reg <= 1'b1;
                // Short frames then read back zero-extended
                rx_sh_reg <= `SSM_RST_WORD;
                gap_rx_reg <= next_rx;
                if (ctrl0_reg[`SSM_C0_TOGGLE] & (next_rx | next_tx)) begin
                  state_reg <= ST_GAP;
                end else if (next_rx) begin
                  // Receive starts only once the control frame is out
                  if (rx_phase_reg) rx_left_reg <= rx_left_reg - 16'h0001;
                  rx_phase_reg <= 1'b1;
                  ctrl_phase_reg <= 1'b0;
                  tx_sh_reg <= `SSM_RST_WORD;
                  clk_left_reg <= dclocks - 6'd1;
                end else if (next_tx) begin
                  tx_sh_reg <= tx_load_d;
                  clk_left_reg <= dclocks - 6'd1;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end
            end
          end
          ST_GAP: begin
            // Half a serial clock period (one tick) deselected, then the next frame
            if (tick) begin
              state_reg <= (gap_rx_reg | fifo_out_valid) ? ST_SHIFT : ST_IDLE;
              clk_left_reg <= dclocks - 6'd1;
              if (gap_rx_reg) begin
                if (rx_phase_reg) rx_left_reg <= rx_left_reg - 16'h0001;
                rx_phase_reg <= 1'b1;
                ctrl_phase_reg <= 1'b0;
                tx_sh_reg <= `SSM_RST_WORD;
              end else begin
                tx_sh_reg <= tx_load_d;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pins and threshold flags, all registered
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_meta_reg <= 4'h0;
      in_sync_reg <= 4'h0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      sd_out <= 4'h0;
      sd_oe <= 4'h0;
      tx_thresh_hit <= 1'b0;
      rx_thresh_hit <= 1'b0;
    end else begin
      in_meta_reg <= sd_in;
      in_sync_reg <= in_meta_reg;
      sclk <= ctrl0_reg[`SSM_C0_POL] ^ (half_reg & state_reg[1]);
      cs_n <= ~(select_reg & ~state_reg[2]);
      sd_out <= out_bits;
      // Half-duplex lanes only drive while the frame carries transmit data
      if (!state_reg[1] || rx_phase_reg) sd_oe <= 4'h0;
      else if (lanes == 3'd1) sd_oe <= 4'h1;
      else if (lanes == 3'd2) sd_oe <= 4'h3;
      else sd_oe <= 4'hF;
      tx_thresh_hit <= ({5'b00000, fill} <= tx_thr_reg);
      rx_thresh_hit <= ({7'b0000000, rx_valid_reg} > rx_thr_reg);
    end
  end
endmodule // ssm_master

/* bench/ssm_master_chk.sv */
// Port-level assertions for the serial master
`timescale 1ns/1ps
module ssm_master_chk (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] sd_oe,
  input wire logic tx_thresh_hit,
  input wire logic rx_thresh_hit
);
  logic wr_done;
  logic sel_reg, en_reg, pol_reg;
  logic [1:0] lanes_reg;
  logic [15:0] div_reg;
  logic [7:0] txt_reg, rxt_reg;
  // Only completed, accepted writes change the shadow
  assign wr_done = psel && penable && pwrite && pready && !pslverr;
  // --------------------------------------------------------------------
  // Shadow of host settings
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sel_reg <= 1'b0;
      en_reg <= 1'b0;
      pol_reg <= 1'b0;
      lanes_reg <= 2'h0;
      div_reg <= 16'h0000;
      txt_reg <= 8'h00;
      rxt_reg <= 8'h00;
    end else if (wr_done) begin
      case (paddr)
        8'h00: begin
          pol_reg <= pwdata[7];
          lanes_reg <= pwdata[22:21];
        end
        8'h08: en_reg <= pwdata[0];
        8'h10: sel_reg <= pwdata[0];
        8'h14: div_reg <= pwdata[15:0];
        8'h18: txt_reg <= pwdata[7:0];
        8'h1C: rxt_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Register setup phase; data window may stall, so it is left out
  sequence s_setup;
    psel && !penable && paddr < 8'h60;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  chk_setup_answer: assert property (s_setup |=> s_answer)
    else $error("register access not answered in one cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  chk_unmapped_err: assert property (pready && paddr > 8'h28 && paddr < 8'h60 |-> pslverr)
    else $error("unmapped address answered without error");
  chk_mapped_ok: assert property (pready && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped register answered with error");
  chk_select_off: assert property (!sel_reg && !$past(sel_reg) |-> cs_n)
    else $error("target selected while select bit is clear");
  chk_select_on: assert property (sel_reg && $past(sel_reg, 2) && !en_reg && !$past(en_reg) && !$past(en_reg, 2) |-> !cs_n)
    else $error("target not selected while select bit is set");
  chk_div_still: assert property (div_reg == 16'h0000 && $past(div_reg, 2) == 16'h0000 && $past(pol_reg, 2) == pol_reg |-> sclk == pol_reg)
    else $error("serial clock moved with zero divisor");
  chk_sclk_half: assert property (en_reg && div_reg >= 16'h0004 && $changed(sclk) |=> $stable(sclk))
    else $error("serial clock half period shorter than divisor allows");
  chk_tx_full_thr: assert property (txt_reg == 8'hFF && $past(txt_reg, 2) == 8'hFF |-> tx_thresh_hit)
    else $error("transmit threshold flag low with maximum threshold");
  chk_rx_high_thr: assert property (rxt_reg != 8'h00 && $past(rxt_reg, 2) != 8'h00 |-> !rx_thresh_hit)
    else $error("receive threshold flag high above possible level");
  chk_one_lane: assert property (lanes_reg == 2'h0 && $past(lanes_reg, 2) == 2'h0 |-> sd_oe[3:1] == 3'h0)
    else $error("extra lanes driven in single lane format");
endmodule // ssm_master_chk

bind ssm_master ssm_master_chk chk_u (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
  .cs_n(cs_n), .sd_oe(sd_oe), .tx_thresh_hit(tx_thresh_hit), .rx_thresh_hit(rx_thresh_hit)
);

/* bench/ssm_target_model.sv */
// Behavioural serial target: records host bits, answers a fixed pattern
`timescale 1ns/1ps
module ssm_target_model #(
  parameter logic [31:0] REPLY = 32'hC3A596E1
) (
  input wire logic clock,
  input wire logic slow,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] sd_out,
  input wire logic [3:0] sd_oe,
  output wire logic [3:0] sd_in,
  output logic [31:0] heard,
  output int rises
);
  logic bitv;
  logic wander = 1'b0;
  wire [3:0] tgt;
  // Selection restarts the bit count and shows the first reply bit
  always @(negedge cs_n) begin
    rises <= 0;
    bitv <= REPLY[31];
  end
  // Lane 0 is taken on each rising serial clock while selected
  always @(posedge sclk) begin
    if (!cs_n) begin
      heard <= {heard[30:0], sd_out[0]};
      rises <= rises + 1;
    end
  end
  // Next reply bit after each falling edge, late by 3 ns when slow
  always @(negedge sclk) begin
    if (!cs_n) bitv <= #(slow ? 3 : 0) REPLY[5'd31 - rises[4:0]];
  end
  // Released lines toggle so a stale level never reads as valid
  always @(posedge clock) wander <= ~wander;
  assign tgt = cs_n ? {4{wander}} : {4{bitv}};
  assign sd_in = (sd_oe & sd_out) | (~sd_oe & tgt);
endmodule // ssm_target_model

/* bench/ssm_master_bench.sv */
// Self-checking bench for the serial master: registers, FIFO, link
`timescale 1ns/1ps
module ssm_master_bench;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic slow = 1'b0;
  wire [31:0] prdata, heard;
  wire pready, pslverr, sclk, cs_n, tx_thresh_hit, rx_thresh_hit;
  wire [3:0] sd_out, sd_oe, sd_in;
  int rises, fails = 0, checked = 0, i, j, n;
  logic [33:0] expq[$];
  logic [33:0] e;
  logic [31:0] rd, d;
  logic [31:0] w[5];
  logic [31:0] mask[9] = '{32'h017FFFFF, 32'hFFFF, 32'h1, 32'h7, 32'h1, 32'hFFFF, 32'hFF,
                           32'hFF, 32'h0};
  logic [3:0] oe_mask[3] = '{4'h1, 4'h3, 4'hF};
  ssm_master dut_u (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .sd_out(sd_out), .sd_oe(sd_oe),
    .sd_in(sd_in), .tx_thresh_hit(tx_thresh_hit), .rx_thresh_hit(rx_thresh_hit));
  ssm_target_model tgt_u (.clock(clock), .slow(slow), .sclk(sclk), .cs_n(cs_n),
    .sd_out(sd_out), .sd_oe(sd_oe), .sd_in(sd_in), .heard(heard), .rises(rises));
  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One bus access; the note is {ignore, error, data}
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dw,
                     input logic [33:0] exp);
    expq.push_back(exp);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dw;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 400);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 400) fails++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dw);
    apb(1'b1, a, dw, 34'h0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {2'b00, x});
  endtask
  // Poll status until the engine is idle and the FIFO empty
  task automatic wait_idle();
    for (int k = 0; k < 100; k++) begin
      apb(1'b0, 8'h28, 32'h0, 34'h200000000);
      if (rd[0] === 1'b0 && rd[2] === 1'b1) return;
    end
    fails++;
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Each finished access is compared with the oldest note, unless that note is marked ignore
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1) begin
      e = expq.pop_front();
      if (!e[33]) check("apb", {1'b0, pslverr, prdata}, {1'b0, e[32:0]});
    end
  end
  initial forever #2 clock = ~clock;
  // Cut a hang short well after the tests should have ended
  initial begin
    #200000;
    fails++;
    close_out();
  end
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(57833));
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    for (i = 0; i <= 8; i++) rdc(8'(i * 4), 32'h0);
    check("cs_n", cs_n, 1);
    check("tx_hit", tx_thresh_hit, 1);
    // All-ones, random, then zeros through the registers from 0x00 to 0x20
    for (int p = 0; p < 3; p++) begin
      for (i = 0; i <= 8; i++) begin
        d = (p == 0) ? 32'hFFFFFFFF : (p == 1) ? $urandom : 32'h0;
        wr(8'(i * 4), d);
        rdc(8'(i * 4), d & mask[i]);
      end
    end
    apb(1'b1, 8'h2C, 32'hFFFFFFFF, 34'h100000000);
    apb(1'b0, 8'h03, 32'h0, 34'h100000000);
    // Fill with the engine off, then drain while a fifth word is written to 0xEC
    wr(8'h00, 32'h00070000);
    wr(8'h14, 32'h4);
    wr(8'h18, 32'h1);
    wr(8'h10, 32'h1);
    for (i = 0; i < 5; i++) w[i] = $urandom;
    for (i = 0; i < 4; i++) wr(8'h60 + 8'(i * 4), w[i]);
    rdc(8'h20, 32'h4);
    rdc(8'h28, 32'h0);
    check("tx_hit", tx_thresh_hit, 0);
    wr(8'h08, 32'h1);
    wr(8'hEC, w[4]);
    wait_idle();
    check("bits", rises, 40);
    check("heard", heard, {w[1][7:0], w[2][7:0], w[3][7:0], w[4][7:0]});
    check("tx_hit", tx_thresh_hit, 1);
    // Each lane format drives its own lanes
    for (i = 0; i < 3; i++) begin
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h00070000 | 32'(i << 21) | (32'(i != 0) << 8) | (i == 0 ? 32'h800 : 32'h0));
      wr(8'h08, 32'h1);
      d = $urandom;
      wr(8'h60, d);
      for (j = 0; j < 100 && sd_oe === 4'h0; j++) @(posedge clock);
      check("sd_oe", sd_oe, oe_mask[i]);
      wait_idle();
      // Single lane runs looped back, so the frame returns as sent
      if (i == 0) rdc(8'h60, {24'h000000, d[7:0]});
    end
    // Memory read: four-clock command, eight-clock answer, slow target
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h00073300);
    wr(8'h04, 32'h0);
    wr(8'h14, 32'h10);
    wr(8'h10, 32'h1);
    slow <= 1'b1;
    wr(8'h08, 32'h1);
    wr(8'h60, 32'hA5000000);
    for (j = 0; j < 150; j++) begin
      apb(1'b0, 8'h28, 32'h0, 34'h200000000);
      if (rd[3] === 1'b1) break;
    end
    for (j = 0; j < 4 && rx_thresh_hit !== 1'b1; j++) @(posedge clock);
    check("rx_hit", rx_thresh_hit, 1);
    check("rises", rises, 12);
    rdc(8'h60, 32'h3A);
    for (j = 0; j < 4 && rx_thresh_hit !== 1'b0; j++) @(posedge clock);
    check("rx_hit", rx_thresh_hit, 0);
    close_out();
  end
endmodule // ssm_master_bench
